// [capture_defs.vh]
// Shared constants for the bus cycle capture front end.
// Assumes inclusion by bare name from the design files.
`ifndef CAPTURE_DEFS_VH
`define CAPTURE_DEFS_VH
`define STAT_BIT_STATUS_ONE 0
`define STAT_BIT_BYTE_HIGH 1
`define STAT_BIT_ADDR_LSB 2
`define STAT_BIT_STATUS_ZERO 3
`define STAT_BIT_MEM_IO 4
`define STAT_BIT_CODE_INTA 5
`define STAT_BIT_LOCK 6
`define STAT_BIT_HOLD_ACK 7
`define STATUS_RESET 8'h00
`define MAX_INPUT_CLOCK_MHZ 20
`define FIFO_DEPTH_DEFAULT 16
`endif

// [capture_fifo.v]
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module capture_fifo #(
	parameter WIDTH = 48,
	parameter DEPTH = 16,
	parameter AW = 4
)(
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Fill side
	input wire inValid,
	output wire inReady,
	input wire [WIDTH-1:0] inData,
	// Drain side
	output wire outValid,
	input wire outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr_reg;
	reg [AW-1:0] rdPtr_reg;
	reg [AW:0] count_reg;
	wire doWrite;
	wire doRead;
	assign inReady = (count_reg != DEPTH[AW:0]);
	assign outValid = (count_reg != {(AW+1){1'b0}});
	assign outData = mem[rdPtr_reg];
	assign doWrite = inValid && inReady;
	assign doRead = outValid && outReady;
	always @(posedge core_clk)
	begin
		if (doWrite)
			mem[wrPtr_reg] <= inData;
		if (rst)
		begin
			wrPtr_reg <= {AW{1'b0}};
			rdPtr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end
		else
		begin
			if (doWrite)
				wrPtr_reg <= (wrPtr_reg == DEPTH[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : wrPtr_reg + 1'b1;
			if (doRead)
				rdPtr_reg <= (rdPtr_reg == DEPTH[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : rdPtr_reg + 1'b1;
			if (doWrite && !doRead)
				count_reg <= count_reg + 1'b1;
			else if (doRead && !doWrite)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule
`default_nettype wire

// [bus_cycle_capture.v]
// Bus cycle capture front end: one record per completed bus cycle.
// Assumes all processor pins are synchronous to core_clk, which is the
// processor input clock; one bus state spans two core_clk cycles.
`timescale 1ns/10ps
`default_nettype none
`include "capture_defs.vh"
module bus_cycle_capture #(
	parameter ADDR_WIDTH = 24,
	parameter DATA_WIDTH = 16,
	parameter FIFO_DEPTH = `FIFO_DEPTH_DEFAULT,
	parameter FIFO_AW = 4
)(
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Processor local bus
	input wire procReset,
	input wire busPhase,
	input wire [ADDR_WIDTH-1:0] address,
	input wire [DATA_WIDTH-1:0] data,
	input wire bus_status_n_zero,
	input wire bus_status_n_one,
	input wire byte_high_enable,
	input wire mem_or_io_select,
	input wire code_or_intack_select,
	input wire bus_lock_n,
	input wire hold_acknowledge,
	input wire cycle_ready_n,
	// Analyzer side
	output reg sampleStrobe,
	output reg recValid,
	input wire recReady,
	output reg [ADDR_WIDTH-1:0] recAddress,
	output reg [DATA_WIDTH-1:0] recData,
	output reg [7:0] recStatus,
	output reg recOverflow
);
	// ****************************************
	// Cycle tracking
	// ****************************************
	localparam REC_W = ADDR_WIDTH + DATA_WIDTH + 8;
	localparam ST_IDLE = 4'b0001;
	localparam ST_SEND = 4'b0010;
	localparam ST_CMD = 4'b0100;
	localparam ST_LAST = 4'b1000;
	reg [3:0] state_reg;
	reg [3:0] state_next;
	reg [ADDR_WIDTH-1:0] addrLatch_reg;
	reg [7:0] statLatch_reg;
	reg [DATA_WIDTH-1:0] dataSample_reg;
	reg [DATA_WIDTH-1:0] dataHold_reg;
	reg push_reg;
	wire stateEnd;
	wire cycleStart;
	wire [7:0] statusNow;
	wire fifoInReady;
	wire fifoOutValid;
	wire [REC_W-1:0] fifoOutData;
	wire fifoPush;
	// A bus state ends on the second input clock of its pair.
	assign stateEnd = busPhase;
	assign cycleStart = !bus_status_n_zero || !bus_status_n_one;
	// A push already on its way is dropped together with its strobe when
	// the processor is reset, so records and strobes pair up while the FIFO has room.
	assign fifoPush = push_reg && !procReset;
	// Status byte built straight from the pins; fetches are not split
	// into executed and prefetched kinds.
	assign statusNow = {hold_acknowledge,
		bus_lock_n,
		code_or_intack_select,
		mem_or_io_select,
		bus_status_n_zero,
		address[0],
		byte_high_enable,
		bus_status_n_one};
	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
				if (stateEnd && cycleStart)
					state_next = ST_SEND;
			ST_SEND:
				if (stateEnd)
					state_next = ST_CMD;
			ST_CMD:
				if (stateEnd && !cycle_ready_n)
					state_next = ST_LAST;
			ST_LAST:
				if (stateEnd)
					state_next = cycleStart ? ST_SEND : ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end
	// Single core_clk domain keeps timing at 20 MHz trivially.
	always @(posedge core_clk)
	begin
		dataSample_reg <= data;
		if (rst || procReset)
		begin
			state_reg <= ST_IDLE;
			addrLatch_reg <= {ADDR_WIDTH{1'b0}};
			statLatch_reg <= `STATUS_RESET;
			dataHold_reg <= {DATA_WIDTH{1'b0}};
			push_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			push_reg <= 1'b0;
			if (state_reg == ST_SEND && stateEnd)
			begin
				addrLatch_reg <= address;
				statLatch_reg <= statusNow;
			end
			if (state_reg == ST_CMD && stateEnd && !cycle_ready_n)
				dataHold_reg <= dataSample_reg;
			// Record goes out at the end of the state after the last
			// command state, whether the next state is send or idle.
			if (state_reg == ST_LAST && stateEnd)
				push_reg <= 1'b1;
		end
	end
	// ****************************************
	// Record buffer and outputs
	// ****************************************
	capture_fifo #(
		.WIDTH(REC_W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) recFifo (
		.core_clk(core_clk),
		.rst(rst),
		.inValid(fifoPush),
		.inReady(fifoInReady),
		.inData({addrLatch_reg, dataHold_reg, statLatch_reg}),
		.outValid(fifoOutValid),
		.outReady(recReady && recValid),
		.outData(fifoOutData)
	);
	// The strobe is a registered pulse one core_clk after the state end,
	// which is a rising edge of core_clk, the processor input clock.
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			sampleStrobe <= 1'b0;
			recValid <= 1'b0;
			recAddress <= {ADDR_WIDTH{1'b0}};
			recData <= {DATA_WIDTH{1'b0}};
			recStatus <= `STATUS_RESET;
			recOverflow <= 1'b0;
		end
		else
		begin
			sampleStrobe <= fifoPush;
			if (fifoPush && !fifoInReady)
				recOverflow <= 1'b1;
			if (!recValid || recReady)
			begin
				recValid <= 1'b0;
				if (fifoOutValid && !(recValid && recReady))
				begin
					recValid <= 1'b1;
					{recAddress, recData, recStatus} <= fifoOutData;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [bus_cycle_capture_checker.sv]
// Concurrent checks on the ports of the bus cycle capture front end.
// Assumes one clock, core_clk, and a synchronous active-high rst.
`timescale 1ns/10ps
`default_nettype none
module bus_cycle_capture_checker (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Bus side
	input wire logic procReset,
	input wire logic busPhase,
	// Analyzer side
	input wire logic recReady,
	input wire logic sampleStrobe,
	input wire logic recValid,
	input wire logic [7:0] recStatus,
	input wire logic recOverflow
);
	// Strobes issued whose records the analyzer has not yet taken.
	logic [7:0] pendCount_reg;
	always @(posedge core_clk)
	begin
		if (rst)
			pendCount_reg <= 8'h00;
		else
			pendCount_reg <= pendCount_reg + {7'h00, sampleStrobe} -
				{7'h00, recValid && recReady};
	end
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	sequence quietGap;
		!sampleStrobe [*5];
	endsequence
	chk_strobe_phase: assert property (
		sampleStrobe |-> $past(busPhase, 2))
		else $error("strobe not one clock after a state end");
	chk_strobe_gap: assert property (sampleStrobe |=> quietGap)
		else $error("strobes closer than one bus cycle");
	chk_reset_quiet: assert property (procReset [*2] |=> !sampleStrobe)
		else $error("strobe during processor reset");
	chk_record_held: assert property (recValid && !recReady
		|=> recValid && $stable(recStatus)) else $error("record lost");
	chk_strobe_record: assert property (
		sampleStrobe && !recValid |=> recValid)
		else $error("no record after strobe");
	chk_record_cause: assert property (
		!recValid && !sampleStrobe && pendCount_reg == 8'h00 |=> !recValid)
		else $error("record without strobe");
	chk_overflow_sticky: assert property (recOverflow |=> recOverflow)
		else $error("overflow flag cleared");
	chk_reset_outputs: assert property ($fell(rst) |-> !recValid
		&& !sampleStrobe && !recOverflow) else $error("outputs not cleared");
endmodule
bind bus_cycle_capture bus_cycle_capture_checker monitor (.core_clk, .rst,
	.procReset, .busPhase, .recReady, .sampleStrobe, .recValid, .recStatus,
	.recOverflow);
`default_nettype wire

// [proc_bus_model.sv]
// Processor local bus model: runs one bus cycle per call of runCycle.
// Assumes it shares core_clk and rst with the capture block.
`timescale 1ns/10ps
`default_nettype none
module proc_bus_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Bus pins
	output logic busPhase = 1'b0,
	output logic [23:0] address = 24'h0,
	output logic [15:0] data = 16'h0,
	output logic [7:0] pins = 8'hFF,
	output logic cycle_ready_n = 1'b1
);
	always @(posedge core_clk)
		busPhase <= rst ? 1'b0 : ~busPhase;
	// Released lines show inverted values, except the two status lines, which go high, so stale data cannot pass.
	task runCycle(input logic [23:0] a, input logic [15:0] d,
		input logic [7:0] s, input int w);
		@(posedge core_clk);
		while (busPhase)
			@(posedge core_clk);
		address <= {a[23:1], s[2]};
		pins <= s;
		repeat (3) @(posedge core_clk);
		address <= ~{a[23:1], s[2]};
		pins <= ~s | 8'h09;
		data <= d;
		cycle_ready_n <= (w == 0) ? 1'b0 : 1'b1;
		repeat (2 * w) @(posedge core_clk);
		if (w != 0)
			cycle_ready_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		data <= ~d;
		cycle_ready_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the bus cycle capture front end.
// Assumes proc_bus_model drives the processor side of the block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic procReset = 1'b0;
	logic recReady = 1'b0;
	logic busPhase, cycle_ready_n, sampleStrobe, recValid, recOverflow;
	logic [23:0] address, recAddress;
	logic [15:0] data, recData;
	logic [7:0] pins, recStatus;
	logic [47:0] q[$];
	logic [7:0] tbl [10] = '{8'h00, 8'h50, 8'h1A, 8'h5A, 8'h95, 8'h68, 8'hE1,
		8'h78, 8'h18, 8'h21};
	int badCount = 0;
	int totalChecks = 0;
	int strobes = 0;
	int s0;
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk)
		if (sampleStrobe === 1'b1)
			strobes <= strobes + 1;
	proc_bus_model bus (.core_clk, .rst, .busPhase, .address, .data, .pins,
		.cycle_ready_n);
	bus_cycle_capture dut (.core_clk, .rst, .procReset, .busPhase, .address,
		.data, .bus_status_n_zero(pins[3]), .bus_status_n_one(pins[0]),
		.byte_high_enable(pins[1]), .mem_or_io_select(pins[4]),
		.code_or_intack_select(pins[5]), .bus_lock_n(pins[6]),
		.hold_acknowledge(pins[7]), .cycle_ready_n, .sampleStrobe, .recValid,
		.recReady, .recAddress, .recData, .recStatus, .recOverflow);
	task chk(input logic [47:0] got, input logic [47:0] exp);
		totalChecks++;
		if (got !== exp)
		begin
			badCount++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task cyc(input logic [7:0] s, input int w);
		logic [47:0] rec;
		rec = {24'hA50000 | 24'(q.size() * 2) | 24'(s[2]),
			16'h3C00 + 16'(q.size()), s};
		q.push_back(rec);
		bus.runCycle(rec[47:24], rec[23:8], s, w);
	endtask
	task drain();
		int n;
		while (q.size() > 0)
		begin
			n = 0;
			while (recValid !== 1'b1 && n < 50)
			begin
				@(posedge core_clk);
				n++;
			end
			chk({47'h0, recValid}, 48'h1);
			chk({recAddress, recData, recStatus}, q.pop_front());
			recReady <= 1'b1;
			@(posedge core_clk);
			recReady <= 1'b0;
			@(posedge core_clk);
		end
	endtask
	task codesTest();
		s0 = strobes;
		foreach (tbl[i])
			cyc(tbl[i], i % 3);
		repeat (6) @(posedge core_clk);
		chk(48'(strobes - s0), 48'hA);
		drain();
	endtask
	task overflowTest();
		chk({47'h0, recOverflow}, 48'h0);
		repeat (18) cyc(8'h38, 0);
		repeat (2) q.delete(q.size() - 1);
		repeat (6) @(posedge core_clk);
		chk({47'h0, recOverflow}, 48'h1);
		drain();
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
	endtask
	task procResetTest();
		s0 = strobes;
		fork
			bus.runCycle(24'h000100, 16'hBEEF, 8'h18, 3);
			begin
				repeat (6) @(posedge core_clk);
				procReset <= 1'b1;
				repeat (3) @(posedge core_clk);
				procReset <= 1'b0;
			end
		join
		repeat (6) @(posedge core_clk);
		chk({47'h0, recValid}, 48'h0);
		chk(48'(strobes - s0), 48'h0);
		cyc(8'h28, 1);
		drain();
	endtask
	task results();
		$display("checks %0d mismatches %0d", totalChecks, badCount);
		if (badCount == 0 && totalChecks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		codesTest();
		overflowTest();
		procResetTest();
		results();
	end
	initial
	begin
		repeat (5000) @(posedge core_clk);
		badCount++;
		results();
	end
endmodule
`default_nettype wire
